// file: dv/branch_ref_pkg.sv
// Reference decode and condition of the conditional branches.
// Assumes 32-bit instruction words and 64-bit operands.
package branch_ref_pkg;
   // Returns {isBranch, likely, link, taken}.
   function automatic logic [3:0] brRef(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b);
      logic c;
      case (i[29:26])
         4'h4: c = a == b;
         4'h5: c = a != b;
         4'h6: c = a[63] || a == 64'h0;
         4'h7: c = !a[63] && a != 64'h0;
         default: c = i[16] ? !a[63] : a[63];
      endcase
      if (i[31:26] == 6'h01)
         return {i[19:18] == 2'h0, i[17], i[20], c};
      return {!i[31] && i[29:28] == 2'h1, i[30], 1'h0, c};
   endfunction
endpackage

// file: dv/branch_unit_monitor.sv
// Port checks for the conditional branch unit, bound into every instance.
// Assumes clkEn low freezes the unit, so a frozen cycle never counts as an issue.
`timescale 1ns/1ns
module branch_unit_monitor
   import cond_branch_pkg::*, branch_ref_pkg::*;
(
   input wire logic            clk,
   input wire logic            sys_rst,
   input wire logic            clkEn,
   input wire logic            issueValid,
   input wire logic [31:0]     instr,
   input wire logic [XLEN-1:0] instrAddr,
   input wire logic [XLEN-1:0] sourceRegA,
   input wire logic [XLEN-1:0] sourceRegB,
   input wire logic            branchSeen,
   input wire logic            redirect,
   input wire logic [XLEN-1:0] redirectAddr,
   input wire logic            nullifySlot,
   input wire logic            linkWrite,
   input wire logic [4:0]      linkRegNum,
   input wire logic [XLEN-1:0] linkData,
   input wire logic            srcIsLinkReg
);
   logic [3:0] r;
   logic       take, nulExp, src31, slot_d, slot_q;
   assign r      = brRef(instr, sourceRegA, sourceRegB);
   assign take   = clkEn && issueValid && r[3] && !slot_q;
   assign nulExp = r[2] && !r[0];
   assign src31  = instr[25:21] == 5'h1f;
   // A branch sitting in a delay slot must not count as a new take.
   assign slot_d = take || (slot_q && !(clkEn && issueValid));
   always_ff @(posedge clk)
      slot_q <= sys_rst ? 1'h0 : slot_d;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence slotAfter(t);
      take && r[0] == t ##1 clkEn && issueValid;
   endsequence
   take_seen_a: assert property (take |=> branchSeen) else $error("branch missed");
   slot_refuse_a: assert property (slot_q && clkEn && issueValid |=> !branchSeen) else $error("slot decoded");
   nullify_likely_a: assert property (take |=> nullifySlot == $past(nulExp)) else $error("nullify wrong");
   link_data_a: assert property (take && r[1] |=> linkWrite && linkData == $past(instrAddr) + 64'h8)
      else $error("link wrong");
   link_src_a: assert property (take && r[1] |=> srcIsLinkReg == $past(src31)) else $error("source flag");
   taken_redirect_a: assert property (slotAfter(1'h1) |=> redirect) else $error("redirect missed");
   fall_through_a: assert property (slotAfter(1'h0) |=> !redirect) else $error("stray redirect");
   redirect_once_a: assert property (redirect && clkEn |=> !redirect) else $error("redirect held");
   link_num_a: assert property (linkWrite |-> linkRegNum == 5'h1f) else $error("link register");
endmodule // branch_unit_monitor
bind conditional_branch_unit branch_unit_monitor branch_unit_monitor_i (.clk, .sys_rst, .clkEn, .issueValid,
   .instr, .instrAddr, .sourceRegA, .sourceRegB, .branchSeen, .redirect, .redirectAddr, .nullifySlot, .linkWrite,
   .linkRegNum, .linkData, .srcIsLinkReg);

// file: dv/conditional_branch_unit_test.sv
// Self-checking bench for the conditional branch unit.
// Assumes the register file model supplies operands; inputs move on falling edges.
`timescale 1ns/1ns
module conditional_branch_unit_test;
   import cond_branch_pkg::*, branch_ref_pkg::*;
   logic            clk, sys_rst, clkEn, issueValid, branchSeen, redirect, nullifySlot, linkWrite, srcIsLinkReg;
   logic [31:0]     instr;
   logic [XLEN-1:0] instrAddr, sourceRegA, sourceRegB, redirectAddr, linkData, addr, tgt;
   logic [4:0]      linkRegNum, rs;
   logic [3:0]      e, k;
   int              bad_count, n_tests;
   conditional_branch_unit conditional_branch_unit_i (.clk, .sys_rst, .clkEn, .issueValid, .instr, .instrAddr,
      .sourceRegA, .sourceRegB, .branchSeen, .redirect, .redirectAddr, .nullifySlot, .linkWrite, .linkRegNum,
      .linkData, .srcIsLinkReg);
   gpr_file_model gpr_file_model_i (.clk, .clkEn, .instr, .linkWrite, .linkRegNum, .linkData, .sourceRegA, .sourceRegB);
   ////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   initial begin
      #300000;
      bad_count++;
      summarize();
   end
   initial begin
      sys_rst = 1'h1;
      clkEn = 1'h1;
      issueValid = 1'h0;
      instr = 32'h0;
      instrAddr = 64'h0;
      for (int j = 0; j < 32; j++)
         gpr_file_model_i.regs[j] = 64'h0;
      void'($urandom(22767));
      repeat (4) @(negedge clk);
      sys_rst = 1'h0;
      chk(redirectAddr, 64'h0);
      chk(linkRegNum, 5'h1f);
      for (int n = 0; n < 400; n++) begin
         k = 4'(n);
         rs = ($urandom % 8 == 0) ? 5'h1f : 5'(1 + $urandom % 2);
         addr = {$urandom, $urandom} & ~64'h3;
         // Sign and zero boundaries decide most conditions, so half the operands sit on them.
         for (int j = 0; j < 3; j++)
            gpr_file_model_i.regs[j == 2 ? 31 : j + 1] =
               ($urandom % 2) ? {$urandom, $urandom} : {1'($urandom), 62'h0, 1'($urandom)};
         if (k < 4'h8)
            instr = {1'h0, k[2], 2'h1, k[1:0], rs, k[1] ? 5'h0 : 5'h2, 16'($urandom)};
         else
            instr = {6'h01, rs, k[2], 2'h0, k[1:0], 16'($urandom)};
         e = brRef(instr, gpr_file_model_i.regs[rs], gpr_file_model_i.regs[instr[20:16]]);
         tgt = addr + 64'h4 + {{46{instr[15]}}, instr[15:0], 2'h0};
         instrAddr = addr;
         issueValid = 1'h1;
         @(negedge clk);
         chk(branchSeen, 1'h1);
         chk(nullifySlot, e[2] & ~e[0]);
         chk(linkWrite, e[1]);
         chk(srcIsLinkReg, e[1] && rs == 5'h1f);
         instr = {6'h05, 26'($urandom)};
         instrAddr = addr + 64'h4;
         // A frozen cycle before the slot must hold branchSeen and linkWrite and delay the redirect.
         if ($urandom % 4 == 0) begin
            clkEn = 1'h0;
            @(negedge clk);
            chk(branchSeen, 1'h1);
            chk(redirect, 1'h0);
            chk(linkWrite, e[1]);
            clkEn = 1'h1;
         end
         @(negedge clk);
         chk(redirect, e[0]);
         chk(branchSeen, 1'h0);
         if (e[0])
            chk(redirectAddr, tgt);
         if (e[1])
            chk(gpr_file_model_i.regs[31], addr + 64'h8);
         if ($urandom % 2) begin
            instr = {6'h09, 26'($urandom)};
            issueValid = 1'($urandom);
            @(negedge clk);
            chk(branchSeen, 1'h0);
         end
      end
      summarize();
   end
endmodule // conditional_branch_unit_test

// file: dv/gpr_file_model.sv
// Register file behind the branch unit: supplies operands, takes link writes.
// Assumes the bench preloads regs between clock edges.
`timescale 1ns/1ns
module gpr_file_model
   import cond_branch_pkg::*;
(
   input  wire logic [0:0]      clk,
   input  wire logic [0:0]      clkEn,
   input  wire logic [31:0]     instr,
   input  wire logic [0:0]      linkWrite,
   input  wire logic [4:0]      linkRegNum,
   input  wire logic [XLEN-1:0] linkData,
   output logic      [XLEN-1:0] sourceRegA,
   output logic      [XLEN-1:0] sourceRegB
);
   logic [XLEN-1:0] regs [32];
   assign sourceRegA = regs[instr[25:21]];
   assign sourceRegB = regs[instr[20:16]];
   // Testing register 31 is let through on purpose, since nothing traps it.
   // A held link pulse in a frozen cycle is not a second write.
   always @(posedge clk)
      if (clkEn && linkWrite)
         regs[linkRegNum] <= linkData;
endmodule // gpr_file_model

// file: hdl/branch_decode_if.sv
// Carries the decoded branch class from the decode helper to the branch unit.
// Assumes both ends share the pipeline clock.
`timescale 1ns/1ns
interface branch_decode_if;
   import cond_branch_pkg::*;
   logic  isBranch;
   cond_t cond;
   logic  likely;
   logic  link;
   modport decoder (output isBranch, output cond, output likely, output link);
   modport user    (input isBranch, input cond, input likely, input link);
endinterface

// file: hdl/branch_decoder.sv
// Combinational decode of the conditional branch opcodes.
// Assumes the instruction word is stable while it is presented.
`timescale 1ns/1ns
module branch_decoder
   import cond_branch_pkg::*;
(
   input wire logic [31:0]     instr,
   branch_decode_if.decoder    dec
);

   always_comb begin
      dec.isBranch = 1'b1;
      dec.cond     = COND_EQUAL;
      dec.likely   = 1'b0;
      dec.link     = 1'b0;
      case (instr[OP_MSB:OP_LSB])
         OPC_EQUAL:           dec.cond = COND_EQUAL;
         OPC_EQUAL_LIKELY: begin
            dec.cond   = COND_EQUAL;
            dec.likely = 1'b1;
         end
         OPC_UNEQUAL:         dec.cond = COND_UNEQUAL;
         OPC_UNEQUAL_LIKELY: begin
            dec.cond   = COND_UNEQUAL;
            dec.likely = 1'b1;
         end
         OPC_NONPOS:          dec.cond = COND_NONPOS;
         OPC_NONPOS_LIKELY: begin
            dec.cond   = COND_NONPOS;
            dec.likely = 1'b1;
         end
         OPC_POSITIVE:        dec.cond = COND_POSITIVE;
         OPC_POSITIVE_LIKELY: begin
            dec.cond   = COND_POSITIVE;
            dec.likely = 1'b1;
         end
         OPC_REG_IMM_GROUP: begin
            case (instr[SUB_MSB:SUB_LSB])
               SUB_NEGATIVE:        dec.cond = COND_NEGATIVE;
               SUB_NONNEG:          dec.cond = COND_NONNEG;
               SUB_NEGATIVE_LIKELY: begin
                  dec.cond   = COND_NEGATIVE;
                  dec.likely = 1'b1;
               end
               SUB_NONNEG_LIKELY: begin
                  dec.cond   = COND_NONNEG;
                  dec.likely = 1'b1;
               end
               SUB_NEGATIVE_LINK: begin
                  dec.cond = COND_NEGATIVE;
                  dec.link = 1'b1;
               end
               SUB_NONNEG_LINK: begin
                  dec.cond = COND_NONNEG;
                  dec.link = 1'b1;
               end
               SUB_NEG_LINK_LIKELY: begin
                  dec.cond   = COND_NEGATIVE;
                  dec.likely = 1'b1;
                  dec.link   = 1'b1;
               end
               SUB_NONNEG_LINK_LKY: begin
                  dec.cond   = COND_NONNEG;
                  dec.likely = 1'b1;
                  dec.link   = 1'b1;
               end
               default:             dec.isBranch = 1'b0;
            endcase
         end
         default:             dec.isBranch = 1'b0;
      endcase
   end

endmodule // branch_decoder

// file: hdl/cond_branch_pkg.sv
// Constants and types shared by the conditional branch unit and its decode helper.
// Assumes a 64-bit datapath and 32-bit instruction words.
package cond_branch_pkg;

   localparam int XLEN         = 64;
   localparam int OP_MSB       = 31;
   localparam int OP_LSB       = 26;
   localparam int SRCA_MSB     = 25;
   localparam int SRCA_LSB     = 21;
   localparam int SUB_MSB      = 20;
   localparam int SUB_LSB      = 16;
   localparam int DISP_MSB     = 15;
   localparam int DISP_WIDTH   = 16;
   localparam int DISP_SHIFT   = 2;
   localparam int LINK_REG_NUM = 31;

   localparam logic [5:0] OPC_REG_IMM_GROUP   = 6'h01;
   localparam logic [5:0] OPC_EQUAL           = 6'h04;
   localparam logic [5:0] OPC_UNEQUAL         = 6'h05;
   localparam logic [5:0] OPC_NONPOS          = 6'h06;
   localparam logic [5:0] OPC_POSITIVE        = 6'h07;
   localparam logic [5:0] OPC_EQUAL_LIKELY    = 6'h14;
   localparam logic [5:0] OPC_UNEQUAL_LIKELY  = 6'h15;
   localparam logic [5:0] OPC_NONPOS_LIKELY   = 6'h16;
   localparam logic [5:0] OPC_POSITIVE_LIKELY = 6'h17;

   localparam logic [4:0] SUB_NEGATIVE        = 5'h00;
   localparam logic [4:0] SUB_NONNEG          = 5'h01;
   localparam logic [4:0] SUB_NEGATIVE_LIKELY = 5'h02;
   localparam logic [4:0] SUB_NONNEG_LIKELY   = 5'h03;
   localparam logic [4:0] SUB_NEGATIVE_LINK   = 5'h10;
   localparam logic [4:0] SUB_NONNEG_LINK     = 5'h11;
   localparam logic [4:0] SUB_NEG_LINK_LIKELY = 5'h12;
   localparam logic [4:0] SUB_NONNEG_LINK_LKY = 5'h13;

   localparam logic [XLEN-1:0] DELAY_SLOT_STEP = 64'h0000_0000_0000_0004;
   localparam logic [XLEN-1:0] LINK_STEP       = 64'h0000_0000_0000_0008;
   localparam logic [XLEN-1:0] ADDR_RESET      = 64'h0000_0000_0000_0000;

   typedef enum logic [2:0] {
      COND_EQUAL    = 3'b000,
      COND_UNEQUAL  = 3'b001,
      COND_NONNEG   = 3'b010,
      COND_NEGATIVE = 3'b011,
      COND_POSITIVE = 3'b100,
      COND_NONPOS   = 3'b101
   } cond_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SLOT  = 2'b01
   } state_t;

endpackage

// file: hdl/conditional_branch_unit.sv
// Conditional branch resolve unit: decodes, evaluates, computes target and link.
// Assumes one instruction is issued per enabled cycle with its address and operands.
//
// Functional notes
// - Target is sign-extended displacement shifted left two, plus delay-slot address.
// - Taken branch redirects only after the single delay-slot instruction has issued.
// - Nonneg forms take the branch when source_reg_a sign bit is zero.
// - Positive forms need sign bit zero and a nonzero register.
// - Nonpositive forms take when sign bit set or register is zero.
// - Negative forms take the branch when source_reg_a sign bit is one.
// - Unequal forms take when source_reg_a differs from source_reg_b.
// - Equal forms take when source_reg_a equals source_reg_b.
// - Link forms write address plus eight to link_reg, taken or not.
// - Link forms testing register 31 are not trapped; software must avoid them.
// - Likely forms nullify the delay-slot instruction when not taken.
// - branch_nonneg_link is the register_immediate_group opcode with sub-field 10001.
`timescale 1ns/1ns
module conditional_branch_unit
   import cond_branch_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            sys_rst,
   input  wire logic            clkEn,
   input  wire logic            issueValid,
   input  wire logic [31:0]     instr,
   input  wire logic [XLEN-1:0] instrAddr,
   input  wire logic [XLEN-1:0] sourceRegA,
   input  wire logic [XLEN-1:0] sourceRegB,
   output logic                 branchSeen,
   output logic                 redirect,
   output logic [XLEN-1:0]      redirectAddr,
   output logic                 nullifySlot,
   output logic                 linkWrite,
   output logic [4:0]           linkRegNum,
   output logic [XLEN-1:0]      linkData,
   output logic                 srcIsLinkReg
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode and condition.

   branch_decode_if dec ();

   branch_decoder decoderInst (
      .instr (instr),
      .dec   (dec)
   );

   function automatic logic evalCond(input cond_t c, input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
      logic r;
      r = 1'b0;
      case (c)
         COND_EQUAL:    r = (a == b);
         COND_UNEQUAL:  r = (a != b);
         COND_NONNEG:   r = ~a[XLEN-1];
         COND_NEGATIVE: r = a[XLEN-1];
         COND_POSITIVE: r = ~a[XLEN-1] && (a != '0);
         COND_NONPOS:   r = a[XLEN-1] || (a == '0);
         default:       r = 1'b0;
      endcase
      return r;
   endfunction

   logic            isBranchNow;
   logic            takenNow;
   logic [XLEN-1:0] targetNow;

   always_comb begin
      isBranchNow = issueValid && dec.isBranch;
      takenNow    = evalCond(dec.cond, sourceRegA, sourceRegB);
      targetNow   = (instrAddr + DELAY_SLOT_STEP)
                  + {{(XLEN-DISP_WIDTH-DISP_SHIFT){instr[DISP_MSB]}},
                     instr[DISP_MSB:0], {DISP_SHIFT{1'b0}}};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Branch sequencing: the resolved branch waits for the delay slot to issue.
   // No exception output exists here; faults belong to the slot or target fetch.

   state_t          state_q,   state_d;
   logic            taken_q,   taken_d;
   logic [XLEN-1:0] target_q,  target_d;
   logic            seen_q,    seen_d;
   logic            redir_q,   redir_d;
   logic [XLEN-1:0] raddr_q,   raddr_d;
   logic            null_q,    null_d;
   logic            lwr_q,     lwr_d;
   logic [XLEN-1:0] ldata_q,   ldata_d;
   logic            srcLnk_q,  srcLnk_d;

   always_comb begin
      state_d  = state_q;
      taken_d  = taken_q;
      target_d = target_q;
      seen_d   = 1'b0;
      redir_d  = 1'b0;
      raddr_d  = raddr_q;
      null_d   = 1'b0;
      lwr_d    = 1'b0;
      ldata_d  = ldata_q;
      srcLnk_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (isBranchNow) begin
               seen_d   = 1'b1;
               taken_d  = takenNow;
               target_d = targetNow;
               state_d  = ST_SLOT;
               if (dec.likely && !takenNow) begin
                  null_d = 1'b1;
               end
               if (dec.link) begin
                  lwr_d    = 1'b1;
                  ldata_d  = instrAddr + LINK_STEP;
                  // Flagged for visibility only; restart safety is software's job.
                  srcLnk_d = (instr[SRCA_MSB:SRCA_LSB] == 5'(LINK_REG_NUM));
               end
            end
         end
         ST_SLOT: begin
            // Wait for the delay slot to issue before steering fetch.
            if (issueValid) begin
               state_d = ST_IDLE;
               if (taken_q) begin
                  redir_d = 1'b1;
                  raddr_d = target_q;
               end
               // Not taken and not likely: slot runs, fetch continues in order.
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q  <= ST_IDLE;
         taken_q  <= 1'b0;
         target_q <= ADDR_RESET;
         seen_q   <= 1'b0;
         redir_q  <= 1'b0;
         raddr_q  <= ADDR_RESET;
         null_q   <= 1'b0;
         lwr_q    <= 1'b0;
         ldata_q  <= ADDR_RESET;
         srcLnk_q <= 1'b0;
      end else if (clkEn) begin
         state_q  <= state_d;
         taken_q  <= taken_d;
         target_q <= target_d;
         seen_q   <= seen_d;
         redir_q  <= redir_d;
         raddr_q  <= raddr_d;
         null_q   <= null_d;
         lwr_q    <= lwr_d;
         ldata_q  <= ldata_d;
         srcLnk_q <= srcLnk_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops, except linkRegNum, which is the constant LINK_REG_NUM.

   always_comb begin
      branchSeen   = seen_q;
      redirect     = redir_q;
      redirectAddr = raddr_q;
      nullifySlot  = null_q;
      linkWrite    = lwr_q;
      linkRegNum   = 5'(LINK_REG_NUM);
      linkData     = ldata_q;
      srcIsLinkReg = srcLnk_q;
   end

endmodule // conditional_branch_unit
